// ---- pwl_pkg.sv ----
// Shared constants for the piecewise-linear conversion and hotshot block
package pwl_pkg;
  // ----------------------------------------------------------------
  // Data format and sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam logic [15:0] FULL_SCALE = 16'hFFFF;
  localparam logic [15:0] ZERO_SCALE = 16'h0000;
  localparam int NUM_PTS = 11;
  localparam int LAST_PT = 10;
  localparam int NUM_INST = 2;
  localparam int NUM_SRC = 8;
  localparam int SEL_W = 4;
  localparam logic [3:0] SEL_NC = 4'h0;
  localparam logic [3:0] SEL_CONV0 = 4'h9;
  localparam logic [3:0] SEL_CONV1 = 4'hA;
  localparam int PT_DIV = 10;

  // ----------------------------------------------------------------
  // Register map, word addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] INST1_BASE = 8'h20;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_STATE = 5'h01;
  localparam logic [4:0] OFF_X0 = 5'h02;
  localparam logic [4:0] OFF_Y0 = 5'h0D;
  localparam logic [4:0] OFF_HS_DELAY = 5'h18;
  localparam logic [4:0] OFF_HS_Y = 5'h19;
  localparam logic [4:0] OFF_OUT = 5'h1A;
  localparam logic [7:0] ADDR_FAULT = 8'h40;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h41;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h42;
  localparam int CTRL_INV_BIT = 4;
  localparam int FAULT_FLAG_BIT = 0;
  localparam int FAULT_SHUT_BIT = 1;

  // ----------------------------------------------------------------
  // Interrupt status layout
  // ----------------------------------------------------------------
  localparam int IRQ_W = 3;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_HS0 = 1;
  localparam int IRQ_HS1 = 2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int HS_W = 14;
  localparam logic [13:0] HS_MAX_MS = 14'd10000;
endpackage : pwl_pkg

// ---- pwl_conv.sv ----
// Two-instance piecewise-linear conversion with hotshot and output fault flag
// What this block does
// - The fault flag goes from 0 to 1 while the drive output is shorted to ground or to battery.
// - During supply over- or under-voltage the fault flag stays clear and the drive is shut down.
// - Two independent conversion instances each have one normalized input and one output.
// - Each instance picks its input from any internal output or not-connected, default not-connected.
// - Each instance can invert its input before conversion, off by default.
// - The curve has eleven points, each with a state, an input and an output coordinate.
// - Points switched off are skipped and only active points take part.
// - Between two neighbouring active points the output is the straight line between them.
// - The last point holds a normal output and a hotshot output used after full scale is held.
// - Hotshot applies only with a nonzero delay and full scale held longer than it.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module pwl_conv #(
  parameter int TICK_CYCLES = pwl_pkg::TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [pwl_pkg::NUM_SRC-1:0][15:0] src_in,
  input wire logic short_gnd_in,
  input wire logic short_bat_in,
  input wire logic supply_bad_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [15:0] reg_rdata_out,
  output logic [15:0] conv0_out,
  output logic [15:0] conv1_out,
  output logic fault_out,
  output logic drive_en_out,
  output logic irq_out
);

  // ----------------------------------------------------------------
  // Curve evaluation
  // ----------------------------------------------------------------
  function automatic logic [15:0] pwl_eval(input logic [15:0] x, input logic [10:0][15:0] xs,
                                           input logic [10:0][15:0] ys, input logic [10:0] act);
    int lo;
    int hi;
    logic [16:0] den;
    logic signed [16:0] dy;
    logic signed [33:0] prod;
    logic signed [33:0] quo;
    lo = 0;
    hi = pwl_pkg::LAST_PT;
    // Lower neighbour: last active point at or below x
    for (int i = 1; i < pwl_pkg::LAST_PT; i++) begin
      if (act[i] && xs[i] <= x) lo = i;
    end
    // Upper neighbour: first active point above the lower one
    for (int i = pwl_pkg::LAST_PT - 1; i > 0; i--) begin
      if (act[i] && i > lo) hi = i;
    end
    den = {1'b0, xs[hi]} - {1'b0, xs[lo]};
    dy = $signed({1'b0, ys[hi]}) - $signed({1'b0, ys[lo]});
    prod = 34'(dy * $signed({1'b0, x - xs[lo]}));
    quo = (den == 17'h00000) ? 34'sh000000000 : prod / $signed({1'b0, den});
    if (x == pwl_pkg::FULL_SCALE) return ys[pwl_pkg::LAST_PT];
    return 16'(34'($signed({1'b0, ys[lo]})) + quo);
  endfunction : pwl_eval

  // Source multiplexer, value 0 when not connected
  function automatic logic [15:0] pick_src(input logic [3:0] sel,
                                           input logic [pwl_pkg::NUM_SRC-1:0][15:0] srcs,
                                           input logic [15:0] c0, input logic [15:0] c1);
    if (sel == pwl_pkg::SEL_NC) return pwl_pkg::ZERO_SCALE;
    if (sel == pwl_pkg::SEL_CONV0) return c0;
    if (sel == pwl_pkg::SEL_CONV1) return c1;
    if (sel <= 4'(pwl_pkg::NUM_SRC)) return srcs[3'(sel - 4'h1)];
    return pwl_pkg::ZERO_SCALE;
  endfunction : pick_src

  // ----------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------
  logic [1:0][3:0] sel_q;
  logic [1:0] inv_q;
  logic [1:0][10:0] act_q;
  logic [1:0][10:0][15:0] xs_q;
  logic [1:0][10:0][15:0] ys_q;
  logic [1:0][13:0] hsd_q;
  logic [1:0][15:0] hsy_q;
  logic [1:0][15:0] out_q;
  logic [1:0][13:0] hs_ms_q;
  logic [1:0] hot_q;
  logic [15:0] tick_cnt_q;
  logic tick;
  logic fault_q;
  logic shut_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic [2:0] irq_set;
  logic [1:0][15:0] x_eff;
  logic [1:0] at_full;
  logic [1:0] hot_now;
  logic inst_hit;
  logic inst_sel;
  logic [4:0] off;

  assign inst_hit = reg_addr_in < pwl_pkg::ADDR_FAULT;
  assign inst_sel = reg_addr_in[5];
  assign off = reg_addr_in[4:0];

  // Register writes; end points keep fixed state and input coordinate
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sel_q <= '0;
      inv_q <= '0;
      ys_q <= '0;
      hsd_q <= '0;
      hsy_q <= '0;
      for (int k = 0; k < pwl_pkg::NUM_INST; k++) begin
        act_q[k] <= 11'h401;
        for (int i = 0; i < pwl_pkg::NUM_PTS; i++) begin
          xs_q[k][i] <= 16'((32'(pwl_pkg::FULL_SCALE) * 32'(i)) / 32'(pwl_pkg::PT_DIV));
        end
      end
    end else if (reg_wr_in && inst_hit) begin
      if (off == pwl_pkg::OFF_CTRL) begin
        sel_q[inst_sel] <= reg_wdata_in[3:0];
        inv_q[inst_sel] <= reg_wdata_in[pwl_pkg::CTRL_INV_BIT];
      end
      if (off == pwl_pkg::OFF_STATE) act_q[inst_sel] <= {1'b1, reg_wdata_in[9:1], 1'b1};
      if (off > pwl_pkg::OFF_X0 && off < pwl_pkg::OFF_X0 + 5'd10) begin
        xs_q[inst_sel][4'(off - pwl_pkg::OFF_X0)] <= reg_wdata_in;
      end
      if (off >= pwl_pkg::OFF_Y0 && off <= pwl_pkg::OFF_Y0 + 5'd10) begin
        ys_q[inst_sel][4'(off - pwl_pkg::OFF_Y0)] <= reg_wdata_in;
      end
      if (off == pwl_pkg::OFF_HS_DELAY) begin
        // Whole word compared so large values saturate instead of wrapping
        hsd_q[inst_sel] <= (reg_wdata_in > {2'h0, pwl_pkg::HS_MAX_MS}) ? pwl_pkg::HS_MAX_MS
                                                                       : reg_wdata_in[13:0];
      end
      if (off == pwl_pkg::OFF_HS_Y) hsy_q[inst_sel] <= reg_wdata_in;
    end
  end

  // ----------------------------------------------------------------
  // Millisecond time base
  // ----------------------------------------------------------------
  assign tick = tick_cnt_q == 16'(TICK_CYCLES - 1);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) tick_cnt_q <= 16'h0000;
    else tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
  end

  // ----------------------------------------------------------------
  // Conversion instances
  // ----------------------------------------------------------------
  always_comb begin
    for (int k = 0; k < pwl_pkg::NUM_INST; k++) begin
      x_eff[k] = pick_src(sel_q[k], src_in, out_q[0], out_q[1]);
      if (inv_q[k]) x_eff[k] = pwl_pkg::FULL_SCALE - x_eff[k];
      at_full[k] = x_eff[k] == pwl_pkg::FULL_SCALE;
      hot_now[k] = at_full[k] && hsd_q[k] != 14'h0000 && hs_ms_q[k] > hsd_q[k];
    end
  end

  // Hotshot timer, restarted off full scale, stops one past the longest delay
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hs_ms_q <= '0;
    end else begin
      for (int k = 0; k < pwl_pkg::NUM_INST; k++) begin
        if (!at_full[k]) hs_ms_q[k] <= 14'h0000;
        else if (tick && hs_ms_q[k] <= pwl_pkg::HS_MAX_MS) hs_ms_q[k] <= hs_ms_q[k] + 14'h0001;
      end
    end
  end

  // Registered outputs of both instances
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      out_q <= '0;
      hot_q <= '0;
    end else begin
      for (int k = 0; k < pwl_pkg::NUM_INST; k++) begin
        hot_q[k] <= hot_now[k];
        if (hot_now[k]) out_q[k] <= hsy_q[k];
        else out_q[k] <= pwl_eval(x_eff[k], xs_q[k], ys_q[k], act_q[k]);
      end
    end
  end

  assign conv0_out = out_q[0];
  assign conv1_out = out_q[1];

  // ----------------------------------------------------------------
  // Output fault state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_q <= 1'b0;
      shut_q <= 1'b0;
    end else begin
      fault_q <= (short_gnd_in || short_bat_in) && !supply_bad_in;
      shut_q <= supply_bad_in;
    end
  end

  assign fault_out = fault_q;
  assign drive_en_out = !shut_q;

  // ----------------------------------------------------------------
  // Interrupts and read port
  // ----------------------------------------------------------------
  assign irq_set = {hot_now[1] && !hot_q[1], hot_now[0] && !hot_q[0],
                    ((short_gnd_in || short_bat_in) && !supply_bad_in) && !fault_q};

  // Sticky status, write one to clear, a new event wins
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= 3'h0;
    end else begin
      if (reg_wr_in && reg_addr_in == pwl_pkg::ADDR_IRQ_MASK) irq_mask_q <= reg_wdata_in[2:0];
      if (reg_wr_in && reg_addr_in == pwl_pkg::ADDR_IRQ_STAT) irq_stat_q <= (irq_stat_q & ~reg_wdata_in[2:0]) | irq_set;
      else irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  assign irq_out = |(irq_stat_q & irq_mask_q);

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (!reg_rd_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (inst_hit) begin
      if (off == pwl_pkg::OFF_CTRL) reg_rdata_out <= {11'h000, inv_q[inst_sel], sel_q[inst_sel]};
      else if (off == pwl_pkg::OFF_STATE) reg_rdata_out <= {5'h00, act_q[inst_sel]};
      else if (off >= pwl_pkg::OFF_X0 && off <= pwl_pkg::OFF_X0 + 5'd10)
        reg_rdata_out <= xs_q[inst_sel][4'(off - pwl_pkg::OFF_X0)];
      else if (off >= pwl_pkg::OFF_Y0 && off <= pwl_pkg::OFF_Y0 + 5'd10)
        reg_rdata_out <= ys_q[inst_sel][4'(off - pwl_pkg::OFF_Y0)];
      else if (off == pwl_pkg::OFF_HS_DELAY) reg_rdata_out <= {2'h0, hsd_q[inst_sel]};
      else if (off == pwl_pkg::OFF_HS_Y) reg_rdata_out <= hsy_q[inst_sel];
      else if (off == pwl_pkg::OFF_OUT) reg_rdata_out <= out_q[inst_sel];
      else reg_rdata_out <= 16'h0000;
    end else if (reg_addr_in == pwl_pkg::ADDR_FAULT) begin
      reg_rdata_out <= {14'h0000, shut_q, fault_q};
    end else if (reg_addr_in == pwl_pkg::ADDR_IRQ_STAT) begin
      reg_rdata_out <= {13'h0000, irq_stat_q};
    end else if (reg_addr_in == pwl_pkg::ADDR_IRQ_MASK) begin
      reg_rdata_out <= {13'h0000, irq_mask_q};
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seq_short;
    (short_gnd_in || short_bat_in) && !supply_bad_in;
  endsequence

  sequence seq_full_hold;
    at_full[0] [*2];
  endsequence

  AST_FAULT_SET: assert property (@(posedge clk_in) disable iff (rst_in)
    seq_short |=> fault_out) else $error("fault flag not set on short");
  AST_FAULT_SUPPLY: assert property (@(posedge clk_in) disable iff (rst_in)
    supply_bad_in |=> !fault_out && !drive_en_out) else $error("fault or drive active on supply fault");
  AST_NC_ZERO: assert property (@(posedge clk_in) disable iff (rst_in)
    (sel_q[0] == pwl_pkg::SEL_NC && !inv_q[0] && $stable(ys_q[0][0])) |=> conv0_out == $past(ys_q[0][0]))
    else $error("unconnected input not zero");
  AST_INV_FULL: assert property (@(posedge clk_in) disable iff (rst_in)
    (sel_q[0] == pwl_pkg::SEL_NC && inv_q[0]) |-> at_full[0]) else $error("inverted zero not full scale");
  AST_ENDS_FIXED: assert property (@(posedge clk_in) disable iff (rst_in)
    act_q[0][0] && act_q[0][10] && xs_q[0][0] == 16'h0000 && xs_q[0][10] == pwl_pkg::FULL_SCALE)
    else $error("end points not fixed");
  AST_HS_ZERO: assert property (@(posedge clk_in) disable iff (rst_in)
    hsd_q[0] == 14'h0000 |-> !hot_now[0]) else $error("hotshot with zero delay");
  AST_HS_RESTART: assert property (@(posedge clk_in) disable iff (rst_in)
    !at_full[0] |=> hs_ms_q[0] == 14'h0000 && !hot_q[0]) else $error("hotshot timer not restarted");
  AST_FULL_Y10: assert property (@(posedge clk_in) disable iff (rst_in)
    (seq_full_hold ##0 (!hot_now[0] && $stable(ys_q[0][10]))) |=> conv0_out == $past(ys_q[0][10]))
    else $error("full scale output not point ten");
  AST_HS_OUT: assert property (@(posedge clk_in) disable iff (rst_in)
    hot_now[0] |=> conv0_out == $past(hsy_q[0])) else $error("hotshot value not applied");

endmodule : pwl_conv
`default_nettype wire

// ---- src_model.sv ----
// Model of the internal blocks that feed the conversion sources
`timescale 1ns/10ps
`default_nettype none
module src_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [2:0] idx_in,
  input wire logic [15:0] val_in,
  input wire logic load_in,
  output logic [pwl_pkg::NUM_SRC-1:0][15:0] src_out
);
  // Each source holds its last loaded level, zero from reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      src_out <= '0;
    end else if (load_in) begin
      src_out[idx_in] <= val_in; // Only the source at idx_in takes the new level
    end
  end
endmodule : src_model
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the conversion, hotshot and fault block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_in, rst_in, short_gnd_in, short_bat_in, supply_bad_in;
  logic reg_wr_in, reg_rd_in, load, fault_out, drive_en_out, irq_out;
  logic [7:0] reg_addr_in;
  logic [15:0] reg_wdata_in, reg_rdata_out, conv0_out, conv1_out, val;
  logic [2:0] idx;
  logic [pwl_pkg::NUM_SRC-1:0][15:0] src_in;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;

  // ----------------------------------------------------------------
  // Design, source model and clock
  // ----------------------------------------------------------------
  pwl_conv #(.TICK_CYCLES(10)) dut_u (.clk_in(clk_in), .rst_in(rst_in), .src_in(src_in),
    .short_gnd_in(short_gnd_in), .short_bat_in(short_bat_in), .supply_bad_in(supply_bad_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .conv0_out(conv0_out),
    .conv1_out(conv1_out), .fault_out(fault_out), .drive_en_out(drive_en_out), .irq_out(irq_out));
  src_model src_u (.clk_in(clk_in), .rst_in(rst_in), .idx_in(idx), .val_in(val),
    .load_in(load), .src_out(src_in));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out, exp);
    @(posedge clk_in);
  endtask : rdc

  task automatic src(input logic [2:0] i, input logic [15:0] v);
    idx <= i;
    val <= v;
    load <= 1'b1;
    @(posedge clk_in);
    load <= 1'b0;
  endtask : src

  function automatic logic [7:0] ra(input logic k, input logic [4:0] off);
    return (k ? pwl_pkg::INST1_BASE : 8'h00) + {3'h0, off};
  endfunction : ra

  // Straight line between two active points, truncated
  function automatic logic [15:0] lin(input longint x, xl, xh, yl, yh);
    return 16'(yl + (yh - yl) * (x - xl) / (xh - xl));
  endfunction : lin

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    {short_gnd_in, short_bat_in, supply_bad_in, reg_wr_in, reg_rd_in, load} = '0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 16'h0000;
    idx = 3'h0;
    val = 16'h0000;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    // Defaults and fixed end points
    rdc(ra(0, pwl_pkg::OFF_CTRL), 16'h0000);
    rdc(ra(0, pwl_pkg::OFF_STATE), 16'h0401);
    rdc(ra(1, pwl_pkg::OFF_X0 + 5'h01), 16'h1999);
    rdc(ra(0, pwl_pkg::OFF_X0 + 5'h0A), 16'hFFFF);
    wr(ra(0, pwl_pkg::OFF_X0), 16'h1234);
    wr(ra(0, pwl_pkg::OFF_STATE), 16'h0000);
    rdc(ra(0, pwl_pkg::OFF_X0), 16'h0000);
    rdc(ra(0, pwl_pkg::OFF_STATE), 16'h0401);
    rdc(8'h3F, 16'h0000);
    // Not connected, then source one with a curve
    src(0, 16'h8000);
    wr(ra(0, pwl_pkg::OFF_Y0 + 5'h0A), 16'hF000);
    cyc(1);
    chk(conv0_out, 16'h0000);
    wr(ra(0, pwl_pkg::OFF_CTRL), 16'h0001);
    wr(ra(0, pwl_pkg::OFF_Y0 + 5'h05), 16'h1000);
    chk(conv0_out, lin(32'h8000, 0, 32'hFFFF, 0, 32'hF000));
    wr(ra(0, pwl_pkg::OFF_STATE), 16'h0421);
    cyc(1);
    chk(conv0_out, lin(32'h8000, 32'h7FFF, 32'hFFFF, 32'h1000, 32'hF000));
    src(0, 16'h7FFF);
    cyc(2);
    chk(conv0_out, 16'h1000);
    wr(ra(0, pwl_pkg::OFF_CTRL), 16'h0011);
    cyc(1);
    chk(conv0_out, lin(32'h8000, 32'h7FFF, 32'hFFFF, 32'h1000, 32'hF000));
    // Unconnected and inverted reads as full scale
    wr(ra(0, pwl_pkg::OFF_CTRL), 16'h0010);
    cyc(1);
    chk(conv0_out, 16'hF000);
    wr(ra(0, pwl_pkg::OFF_CTRL), 16'h0001);
    wr(ra(0, pwl_pkg::OFF_STATE), 16'h0401);
    // Full scale with the hotshot off
    src(0, 16'hFFFF);
    cyc(60);
    chk(conv0_out, 16'hF000);
    // Hotshot after three milliseconds
    src(0, 16'h8000);
    wr(ra(0, pwl_pkg::OFF_HS_DELAY), 16'h0003);
    wr(ra(0, pwl_pkg::OFF_HS_Y), 16'h1234);
    wr(pwl_pkg::ADDR_IRQ_MASK, 16'h0002);
    src(0, 16'hFFFF);
    cyc(25);
    chk(conv0_out, 16'hF000);
    chk({15'h0, irq_out}, 16'h0000);
    cyc(40);
    chk(conv0_out, 16'h1234);
    chk({15'h0, irq_out}, 16'h0001);
    rdc(pwl_pkg::ADDR_IRQ_STAT, 16'h0002);
    wr(pwl_pkg::ADDR_IRQ_STAT, 16'h0002);
    chk({15'h0, irq_out}, 16'h0000);
    src(0, 16'h8000);
    cyc(2);
    chk(conv0_out, lin(32'h8000, 0, 32'hFFFF, 0, 32'hF000));
    rdc(ra(0, pwl_pkg::OFF_OUT), 16'h7800);
    wr(ra(0, pwl_pkg::OFF_HS_DELAY), 16'hFFFF);
    rdc(ra(0, pwl_pkg::OFF_HS_DELAY), 16'h2710);
    wr(ra(0, pwl_pkg::OFF_HS_DELAY), 16'h4000);
    rdc(ra(0, pwl_pkg::OFF_HS_DELAY), 16'h2710);
    // Second instance fed from the first
    wr(ra(1, pwl_pkg::OFF_CTRL), 16'h0009);
    wr(ra(1, pwl_pkg::OFF_Y0 + 5'h0A), 16'hFFFF);
    cyc(2);
    chk(conv1_out, lin(lin(32'h8000, 0, 32'hFFFF, 0, 32'hF000), 0, 32'hFFFF, 0, 32'hFFFF));
    // Last plain source, then an unused selection code
    src(7, 16'h4000);
    wr(ra(1, pwl_pkg::OFF_CTRL), 16'h0008);
    cyc(2);
    chk(conv1_out, 16'h4000);
    wr(ra(1, pwl_pkg::OFF_CTRL), 16'h000B);
    cyc(2);
    chk(conv1_out, 16'h0000);
    // Output shorts and supply faults
    short_gnd_in <= 1'b1;
    cyc(3);
    chk({15'h0, fault_out}, 16'h0001);
    rdc(pwl_pkg::ADDR_FAULT, 16'h0001);
    rdc(pwl_pkg::ADDR_IRQ_STAT, 16'h0001);
    wr(pwl_pkg::ADDR_IRQ_MASK, 16'h0001);
    chk({15'h0, irq_out}, 16'h0001);
    short_gnd_in <= 1'b0;
    short_bat_in <= 1'b1;
    supply_bad_in <= 1'b1;
    cyc(3);
    chk({14'h0, fault_out, drive_en_out}, 16'h0000);
    rdc(pwl_pkg::ADDR_FAULT, 16'h0002);
    supply_bad_in <= 1'b0;
    cyc(3);
    chk({14'h0, fault_out, drive_en_out}, 16'h0003);
    wr(pwl_pkg::ADDR_IRQ_STAT, 16'h0001);
    chk({15'h0, irq_out}, 16'h0000);
    results();
  end
endmodule : tb_top
`default_nettype wire
